// File: sft_flash_cmd.sv
// Purpose: Device-side opcode decoder and embedded operation sequencer of a multi-I/O serial flash
// Assumes: Serial clock, select and data are sampled by the 125 MHz core clock
// Notes: Opcode and address shift in on rising serial clock edges; commands act when select rises
`timescale 1ns/1ps
`default_nettype none

module sft_flash_cmd #(
  parameter int PAGE_PROGRAM_CYCLES = sft_pkg::PAGE_PROGRAM_CYCLES,
  parameter int SECTOR_ERASE_CYCLES = sft_pkg::SECTOR_ERASE_CYCLES,
  parameter int PROGRAM_SUSPEND_CYCLES = sft_pkg::PROGRAM_SUSPEND_CYCLES,
  parameter int ERASE_SUSPEND_CYCLES = sft_pkg::ERASE_SUSPEND_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  // Address length setting, same clock domain
  input wire logic addr32_mode,
  // Decoded command report
  output logic cmd_valid,
  output logic [3:0] cmd_code,
  output logic [7:0] cmd_opcode,
  output logic [31:0] cmd_addr,
  output logic [2:0] cmd_addr_bytes,
  output logic [7:0] cmd_max_mhz,
  // Embedded operation status
  output logic write_in_progress_flag,
  output logic op_suspended,
  output logic op_done,
  output logic nv_pe_cycle
);

  typedef enum logic [1:0] {ST_IDLE, ST_OPCODE, ST_ADDR, ST_TAIL} sft_st_t;
  typedef enum logic [1:0] {OP_IDLE, OP_RUN, OP_SUSPENDING, OP_SUSPENDED} sft_op_t;

  typedef struct packed {
    logic [1:0] sck_sync;
    logic [1:0] cs_sync;
    logic [1:0] si_sync;
    logic sck_prev;
    sft_st_t st;
    logic [5:0] bits;
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [2:0] nbytes;
    sft_op_t op;
    logic op_erase;
    logic [15:0] lat;
    logic tstart;
    logic [31:0] tdur;
    logic cmd_valid;
    logic [3:0] cmd_code;
    logic [7:0] cmd_opcode;
    logic [31:0] cmd_addr;
    logic [2:0] cmd_addr_bytes;
    logic [7:0] cmd_max_mhz;
    logic op_done;
    logic nv_pe_cycle;
  } sft_state_t;

  sft_state_t s;
  sft_state_t next_s;
  sft_pkg::sft_dec_t dec;
  sft_pkg::sft_dec_t cur;
  logic sck_rise;
  logic sel;

  sft_timer_if #(.W(32)) tif ();

  sft_op_timer #(.W(32)) u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .t(tif)
  );

  // Only the second stage of each synchroniser is looked at
  assign sck_rise = s.sck_sync[1] & ~s.sck_prev;
  assign sel = ~s.cs_sync[1];
  assign dec = sft_pkg::sft_decode({s.opcode[6:0], s.si_sync[1]});
  assign cur = sft_pkg::sft_decode(s.opcode);

  always_comb begin
    next_s = s;
    next_s.sck_sync = {s.sck_sync[0], sck};
    next_s.cs_sync = {s.cs_sync[0], cs_n};
    next_s.si_sync = {s.si_sync[0], si};
    next_s.sck_prev = s.sck_sync[1];
    next_s.tstart = 1'b0;
    next_s.cmd_valid = 1'b0;
    next_s.op_done = 1'b0;
    next_s.nv_pe_cycle = 1'b0;

    // Command framing
    case (s.st)
      ST_IDLE: begin
        if (sel) begin
          next_s.st = ST_OPCODE;
          next_s.bits = 6'h00;
          next_s.addr = 32'h0000_0000;
        end
      end
      ST_OPCODE, ST_ADDR, ST_TAIL: begin
        if (!sel) begin
          next_s.st = ST_IDLE;
        end else if (sck_rise && s.st == ST_OPCODE) begin
          next_s.opcode = {s.opcode[6:0], s.si_sync[1]};
          next_s.bits = s.bits + 6'h01;
          if (s.bits == 6'h07) begin
            next_s.bits = 6'h00;
            next_s.nbytes = (dec.addr32 || addr32_mode) ? sft_pkg::ADDR_BYTES_LONG
                                                         : sft_pkg::ADDR_BYTES_SHORT;
            next_s.st = dec.has_addr ? ST_ADDR : ST_TAIL;
          end
        end else if (sck_rise && s.st == ST_ADDR) begin
          next_s.addr = {s.addr[30:0], s.si_sync[1]};
          next_s.bits = s.bits + 6'h01;
          if (s.bits == ((s.nbytes == sft_pkg::ADDR_BYTES_LONG) ? 6'h1f : 6'h17)) begin
            next_s.st = ST_TAIL;
          end
        end
      end
      default: next_s.st = ST_IDLE;
    endcase

    // A command acts only if select rises after its opcode and full address
    if (!sel && s.st == ST_TAIL) begin
      next_s.cmd_valid = 1'b1;
      next_s.cmd_code = cur.cmd;
      next_s.cmd_opcode = s.opcode;
      next_s.cmd_addr = s.addr;
      next_s.cmd_addr_bytes = cur.has_addr ? s.nbytes : 3'h0;
      next_s.cmd_max_mhz = cur.max_mhz;
      case (cur.cmd)
        sft_pkg::SFT_CMD_PAGE_PROGRAM, sft_pkg::SFT_CMD_QUAD_PROGRAM: begin
          if (s.op == OP_IDLE) begin
            next_s.op = OP_RUN;
            next_s.op_erase = 1'b0;
            next_s.tstart = 1'b1;
            next_s.tdur = 32'(PAGE_PROGRAM_CYCLES);
          end
        end
        sft_pkg::SFT_CMD_SECTOR_ERASE: begin
          if (s.op == OP_IDLE) begin
            next_s.op = OP_RUN;
            next_s.op_erase = 1'b1;
            next_s.tstart = 1'b1;
            next_s.tdur = 32'(SECTOR_ERASE_CYCLES);
          end
        end
        sft_pkg::SFT_CMD_PROGRAM_SUSPEND: begin
          if (s.op == OP_RUN && !s.op_erase) begin
            next_s.op = OP_SUSPENDING;
            next_s.lat = 16'(PROGRAM_SUSPEND_CYCLES);
          end
        end
        sft_pkg::SFT_CMD_ERASE_SUSPEND: begin
          if (s.op == OP_RUN && s.op_erase) begin
            next_s.op = OP_SUSPENDING;
            next_s.lat = 16'(ERASE_SUSPEND_CYCLES);
          end
        end
        sft_pkg::SFT_CMD_PROGRAM_RESUME: begin
          if (s.op == OP_SUSPENDED && !s.op_erase) begin
            next_s.op = OP_RUN;
          end
        end
        sft_pkg::SFT_CMD_ERASE_RESUME: begin
          if (s.op == OP_SUSPENDED && s.op_erase) begin
            next_s.op = OP_RUN;
          end
        end
        // OTP bits sit in their own array and are not counted
        sft_pkg::SFT_CMD_NV_WRITE: next_s.nv_pe_cycle = 1'b1;
        default: next_s.nv_pe_cycle = 1'b0;
      endcase
    end

    // Embedded operation; the timer is frozen outside OP_RUN
    case (s.op)
      OP_RUN: begin
        if (tif.done) begin
          next_s.op = OP_IDLE;
          next_s.op_done = 1'b1;
        end
      end
      OP_SUSPENDING: begin
        if (tif.done) begin
          // The timer ran out as the suspend arrived: finish rather than lose the pulse
          next_s.op = OP_IDLE;
          next_s.op_done = 1'b1;
        end else if (s.lat <= 16'h0001) begin
          next_s.op = OP_SUSPENDED;
        end else begin
          next_s.lat = s.lat - 16'h0001;
        end
      end
      OP_IDLE, OP_SUSPENDED: next_s.lat = 16'h0000;
      default: next_s.op = OP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.sck_sync <= 2'h0;
      s.cs_sync <= 2'h3;
    end else begin
      s <= next_s;
    end
  end

  assign tif.start = s.tstart;
  assign tif.dur = s.tdur;
  assign tif.pause = (s.op != OP_RUN);

  assign cmd_valid = s.cmd_valid;
  assign cmd_code = s.cmd_code;
  assign cmd_opcode = s.cmd_opcode;
  assign cmd_addr = s.cmd_addr;
  assign cmd_addr_bytes = s.cmd_addr_bytes;
  assign cmd_max_mhz = s.cmd_max_mhz;
  // Busy while running and while a suspend is still settling
  assign write_in_progress_flag = (s.op == OP_RUN) || (s.op == OP_SUSPENDING);
  assign op_suspended = (s.op == OP_SUSPENDED);
  assign op_done = s.op_done;
  assign nv_pe_cycle = s.nv_pe_cycle;

endmodule : sft_flash_cmd
`default_nettype wire

// File: sft_pkg.sv
// Purpose: Shared constants, command codes and decode table for the serial flash opcode/timing block
// Assumes: Core clock of 125 MHz; single-line opcode and address shifting on the data input
// Notes: Embedded operation times are given in their printed units and turned into clock counts here
package sft_pkg;

  localparam int CLK_MHZ = 125;

  // Opcodes
  localparam logic [7:0] OP_NV_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_NORMAL_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_FAST_READ_A32 = 8'h0c;
  localparam logic [7:0] OP_DDR_FAST_READ = 8'h0d;
  localparam logic [7:0] OP_DDR_FAST_READ_A32 = 8'h0e;
  localparam logic [7:0] OP_PAGE_PROGRAM_A32 = 8'h12;
  localparam logic [7:0] OP_NORMAL_READ_A32 = 8'h13;
  localparam logic [7:0] OP_QUAD_PROGRAM = 8'h32;
  localparam logic [7:0] OP_QUAD_PROGRAM_A32 = 8'h34;
  localparam logic [7:0] OP_QUAD_PROGRAM_ALT = 8'h38;
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3b;
  localparam logic [7:0] OP_OTP_PROGRAM = 8'h42;
  localparam logic [7:0] OP_ERASE_SUSPEND = 8'h75;
  localparam logic [7:0] OP_ERASE_RESUME = 8'h7a;
  localparam logic [7:0] OP_PROGRAM_SUSPEND = 8'h85;
  localparam logic [7:0] OP_PROGRAM_RESUME = 8'h8a;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;
  localparam logic [7:0] OP_SECTOR_ERASE_A32 = 8'hdc;

  // Highest allowed serial clock per command, MHz
  localparam logic [7:0] MHZ_STD = 8'h85;
  localparam logic [7:0] MHZ_NORMAL_READ = 8'h32;
  localparam logic [7:0] MHZ_DDR_QUAD = 8'h50;
  localparam logic [7:0] MHZ_DUAL_READ = 8'h68;

  // Embedded operation times
  localparam int PAGE_BYTES = 512;
  localparam int PAGE_PROGRAM_TYP_US = 340;
  localparam int PAGE_PROGRAM_MAX_IND_US = 750;
  localparam int PAGE_PROGRAM_MAX_PLUS_US = 1300;
  localparam int SECTOR_ERASE_TYP_MS = 520;
  localparam int SECTOR_ERASE_MAX_MS = 2600;
  localparam int PROGRAM_SUSPEND_LATENCY_US = 40;
  localparam int ERASE_SUSPEND_LATENCY_US = 45;

  localparam int PAGE_PROGRAM_CYCLES = PAGE_PROGRAM_TYP_US * CLK_MHZ;
  localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TYP_MS * 1000 * CLK_MHZ;
  localparam int PROGRAM_SUSPEND_CYCLES = PROGRAM_SUSPEND_LATENCY_US * CLK_MHZ;
  localparam int ERASE_SUSPEND_CYCLES = ERASE_SUSPEND_LATENCY_US * CLK_MHZ;

  localparam logic [2:0] ADDR_BYTES_SHORT = 3'h3;
  localparam logic [2:0] ADDR_BYTES_LONG = 3'h4;

  typedef enum logic [3:0] {
    SFT_CMD_NONE,
    SFT_CMD_PAGE_PROGRAM,
    SFT_CMD_NORMAL_READ,
    SFT_CMD_FAST_READ,
    SFT_CMD_DDR_FAST_READ,
    SFT_CMD_QUAD_PROGRAM,
    SFT_CMD_DUAL_OUT_READ,
    SFT_CMD_SECTOR_ERASE,
    SFT_CMD_PROGRAM_SUSPEND,
    SFT_CMD_PROGRAM_RESUME,
    SFT_CMD_ERASE_SUSPEND,
    SFT_CMD_ERASE_RESUME,
    SFT_CMD_NV_WRITE,
    SFT_CMD_OTP_PROGRAM
  } sft_cmd_t;

  typedef struct packed {
    sft_cmd_t cmd;
    logic has_addr;
    logic addr32;
    logic [7:0] max_mhz;
  } sft_dec_t;

  function automatic sft_dec_t sft_decode(input logic [7:0] op);
    sft_dec_t d;
    d = '{cmd: SFT_CMD_NONE, has_addr: 1'b0, addr32: 1'b0, max_mhz: MHZ_STD};
    case (op)
      OP_PAGE_PROGRAM: d = '{SFT_CMD_PAGE_PROGRAM, 1'b1, 1'b0, MHZ_STD};
      OP_PAGE_PROGRAM_A32: d = '{SFT_CMD_PAGE_PROGRAM, 1'b1, 1'b1, MHZ_STD};
      OP_NORMAL_READ: d = '{SFT_CMD_NORMAL_READ, 1'b1, 1'b0, MHZ_NORMAL_READ};
      OP_NORMAL_READ_A32: d = '{SFT_CMD_NORMAL_READ, 1'b1, 1'b1, MHZ_NORMAL_READ};
      OP_FAST_READ: d = '{SFT_CMD_FAST_READ, 1'b1, 1'b0, MHZ_STD};
      OP_FAST_READ_A32: d = '{SFT_CMD_FAST_READ, 1'b1, 1'b1, MHZ_STD};
      OP_DDR_FAST_READ: d = '{SFT_CMD_DDR_FAST_READ, 1'b1, 1'b0, MHZ_DDR_QUAD};
      OP_DDR_FAST_READ_A32: d = '{SFT_CMD_DDR_FAST_READ, 1'b1, 1'b1, MHZ_DDR_QUAD};
      OP_QUAD_PROGRAM: d = '{SFT_CMD_QUAD_PROGRAM, 1'b1, 1'b0, MHZ_DDR_QUAD};
      OP_QUAD_PROGRAM_ALT: d = '{SFT_CMD_QUAD_PROGRAM, 1'b1, 1'b0, MHZ_DDR_QUAD};
      OP_QUAD_PROGRAM_A32: d = '{SFT_CMD_QUAD_PROGRAM, 1'b1, 1'b1, MHZ_DDR_QUAD};
      OP_DUAL_OUT_READ: d = '{SFT_CMD_DUAL_OUT_READ, 1'b1, 1'b0, MHZ_DUAL_READ};
      OP_SECTOR_ERASE: d = '{SFT_CMD_SECTOR_ERASE, 1'b1, 1'b0, MHZ_STD};
      OP_SECTOR_ERASE_A32: d = '{SFT_CMD_SECTOR_ERASE, 1'b1, 1'b1, MHZ_STD};
      OP_PROGRAM_SUSPEND: d.cmd = SFT_CMD_PROGRAM_SUSPEND;
      OP_PROGRAM_RESUME: d.cmd = SFT_CMD_PROGRAM_RESUME;
      OP_ERASE_SUSPEND: d.cmd = SFT_CMD_ERASE_SUSPEND;
      OP_ERASE_RESUME: d.cmd = SFT_CMD_ERASE_RESUME;
      OP_NV_WRITE: d.cmd = SFT_CMD_NV_WRITE;
      OP_OTP_PROGRAM: d.cmd = SFT_CMD_OTP_PROGRAM;
      default: d.cmd = SFT_CMD_NONE;
    endcase
    return d;
  endfunction : sft_decode

endpackage : sft_pkg

// File: sft_timer_if.sv
// Purpose: Carrier between the command logic and the embedded operation timer
// Assumes: Both ends on the core clock
// Notes: start is a one-cycle pulse; done is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface sft_timer_if #(parameter int W = 32);
  logic start;
  logic [W-1:0] dur;
  logic pause;
  logic busy;
  logic done;
  modport owner (output start, output dur, output pause, input busy, input done);
  modport timer (input start, input dur, input pause, output busy, output done);
endinterface : sft_timer_if
`default_nettype wire

// File: sft_op_timer.sv
// Purpose: Pausable down-counter that times one embedded program or erase
// Assumes: dur is at least one
// Notes: Pausing freezes the remaining time so a resumed operation finishes its full duration
`timescale 1ns/1ps
`default_nettype none
module sft_op_timer #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Timer port
  sft_timer_if.timer t
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
    logic done;
  } sft_tstate_t;

  sft_tstate_t s;
  sft_tstate_t next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (t.start) begin
      next_s.cnt = t.dur;
      next_s.busy = 1'b1;
    end else if (s.busy && !t.pause) begin
      if (s.cnt <= W'(1)) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.cnt = s.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign t.busy = s.busy;
  assign t.done = s.done;

endmodule : sft_op_timer
`default_nettype wire

// File: sft_flash_cmd_props.sv
// Purpose: Port-level assertions for the serial flash opcode decoder
// Assumes: One clock domain; suspend latencies fit the 16-bit helper counter
// Notes: The helper tracks which kind of operation runs so a suspend is judged against its own latency
`timescale 1ns/1ps
`default_nettype none
module sft_props #(
  parameter int PROGRAM_SUSPEND_CYCLES = 10,
  parameter int ERASE_SUSPEND_CYCLES = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Decoded command report
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [7:0] cmd_opcode,
  input wire logic [2:0] cmd_addr_bytes,
  input wire logic [7:0] cmd_max_mhz,
  // Embedded operation status
  input wire logic write_in_progress_flag,
  input wire logic op_suspended,
  input wire logic op_done,
  input wire logic nv_pe_cycle
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic erasing;
  logic busy_q;
  logic spend;
  logic [15:0] scnt;
  // Counts cycles from an accepted suspend until the flag drops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      erasing <= 1'b0;
      busy_q <= 1'b0;
      spend <= 1'b0;
      scnt <= 16'h0;
    end else begin
      busy_q <= write_in_progress_flag;
      // The flag rises in the same cycle as the report of a starting operation
      if (cmd_valid && write_in_progress_flag && !busy_q && !op_suspended &&
          cmd_code inside {sft_pkg::SFT_CMD_PAGE_PROGRAM, sft_pkg::SFT_CMD_QUAD_PROGRAM,
                           sft_pkg::SFT_CMD_SECTOR_ERASE}) begin
        erasing <= cmd_code == sft_pkg::SFT_CMD_SECTOR_ERASE;
      end
      if (cmd_valid && write_in_progress_flag && !op_suspended &&
          cmd_code == (erasing ? sft_pkg::SFT_CMD_ERASE_SUSPEND : sft_pkg::SFT_CMD_PROGRAM_SUSPEND)) begin
        spend <= 1'b1;
        scnt <= 16'h0;
      end else if (spend && !write_in_progress_flag) begin
        spend <= 1'b0;
      end else if (spend) begin
        scnt <= scnt + 16'h1;
      end
    end
  end

  property p_page_prog;
    cmd_valid && cmd_opcode inside {8'h02, 8'h12} |-> cmd_code == sft_pkg::SFT_CMD_PAGE_PROGRAM && cmd_max_mhz == 8'h85;
  endproperty
  a_page_prog: assert property (p_page_prog) else $error("page program decode wrong");
  property p_rd;
    cmd_valid && cmd_opcode inside {8'h03, 8'h13} |-> cmd_code == sft_pkg::SFT_CMD_NORMAL_READ && cmd_max_mhz == 8'h32;
  endproperty
  a_rd: assert property (p_rd) else $error("normal read decode wrong");
  property p_fr;
    cmd_valid && cmd_opcode inside {8'h0b, 8'h0c} |-> cmd_code == sft_pkg::SFT_CMD_FAST_READ && cmd_max_mhz == 8'h85;
  endproperty
  a_fr: assert property (p_fr) else $error("fast read decode wrong");
  property p_ddr;
    cmd_valid && cmd_opcode inside {8'h0d, 8'h0e} |-> cmd_code == sft_pkg::SFT_CMD_DDR_FAST_READ && cmd_max_mhz == 8'h50;
  endproperty
  a_ddr: assert property (p_ddr) else $error("double rate read decode wrong");
  property p_quad_prog;
    cmd_valid && cmd_opcode inside {8'h32, 8'h34, 8'h38}
      |-> cmd_code == sft_pkg::SFT_CMD_QUAD_PROGRAM && cmd_max_mhz == 8'h50;
  endproperty
  a_quad_prog: assert property (p_quad_prog) else $error("quad program decode wrong");
  property p_dual_read;
    cmd_valid && cmd_opcode == 8'h3b |-> cmd_code == sft_pkg::SFT_CMD_DUAL_OUT_READ && cmd_max_mhz == 8'h68;
  endproperty
  a_dual_read: assert property (p_dual_read) else $error("dual read decode wrong");
  property p_a32;
    cmd_valid && cmd_opcode inside {8'h12, 8'h13, 8'h0c, 8'h0e, 8'h34} |-> cmd_addr_bytes == 3'h4;
  endproperty
  a_a32: assert property (p_a32) else $error("long form without four address bytes");
  property p_psl;
    spend && !erasing |-> scnt <= PROGRAM_SUSPEND_CYCLES + 2;
  endproperty
  a_psl: assert property (p_psl) else $error("program suspend too slow");
  property p_esl;
    spend && erasing |-> scnt <= ERASE_SUSPEND_CYCLES + 2;
  endproperty
  a_esl: assert property (p_esl) else $error("erase suspend too slow");
  property p_start;
    cmd_valid && !busy_q && !op_suspended &&
      cmd_code inside {sft_pkg::SFT_CMD_PAGE_PROGRAM, sft_pkg::SFT_CMD_QUAD_PROGRAM, sft_pkg::SFT_CMD_SECTOR_ERASE}
      |-> write_in_progress_flag [*3];
  endproperty
  a_start: assert property (p_start) else $error("operation did not raise busy");
  property p_done;
    op_done |-> !write_in_progress_flag && $past(write_in_progress_flag);
  endproperty
  a_done: assert property (p_done) else $error("done without busy falling");
  property p_nv;
    cmd_valid || nv_pe_cycle |-> nv_pe_cycle == (cmd_valid && cmd_opcode == 8'h01);
  endproperty
  a_nv: assert property (p_nv) else $error("register wear pulse wrong");
endmodule : sft_props

bind sft_flash_cmd sft_props #(
  .PROGRAM_SUSPEND_CYCLES(PROGRAM_SUSPEND_CYCLES),
  .ERASE_SUSPEND_CYCLES(ERASE_SUSPEND_CYCLES)
) i_props (.clk, .reset_n, .cmd_valid, .cmd_code, .cmd_opcode, .cmd_addr_bytes, .cmd_max_mhz,
  .write_in_progress_flag, .op_suspended, .op_done, .nv_pe_cycle);
`default_nettype wire

// File: sft_host.sv
// Purpose: Behavioural host controller that shifts command frames into the device
// Assumes: Serial clock idles low and stands still between frames
// Notes: Data line is inverted on release so nothing relies on its last value
`timescale 1ns/1ps
`default_nettype none
module sft_host (
  // Serial pins toward the device
  output logic sck,
  output logic cs_n,
  output logic si
);
  realtime last_resume;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    last_resume = 0.0;
  end
  // 8 MHz serial clock stays below every rated limit
  task automatic frame(input logic [7:0] op, input logic [31:0] addr, input int nbits);
    logic [39:0] sh;
    sh = {op, addr};
    while (op inside {8'h75, 8'h85} && $realtime - last_resume < 60.0) #1;
    #40 cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      si = sh[39 - i];
      #62.5 sck = 1'b1;
      #62.5 sck = 1'b0;
    end
    cs_n = 1'b1;
    si = ~si;
    if (op inside {8'h7a, 8'h8a}) last_resume = $realtime;
  endtask : frame
endmodule : sft_host
`default_nettype wire

// File: tb.sv
// Purpose: Self-checking bench for the serial flash opcode decoder
// Assumes: Shortened operation counts; host frames at 8 MHz
// Notes: Counts are large enough that a suspend frame lands mid-operation
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int P_PROG = 400;
  localparam int P_SE = 600;
  localparam int P_PS = 10;
  localparam int P_ES = 12;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic addr32_mode = 1'b0;
  logic sck, cs_n, si, cmd_valid, write_in_progress_flag, op_suspended, op_done, nv_pe_cycle;
  logic [3:0] cmd_code;
  logic [7:0] cmd_opcode, cmd_max_mhz;
  logic [31:0] cmd_addr;
  logic [2:0] cmd_addr_bytes;
  int fail_count = 0;
  int compares = 0;
  always #4 clk = ~clk;
  sft_host i_host (.sck(sck), .cs_n(cs_n), .si(si));
  sft_flash_cmd #(.PAGE_PROGRAM_CYCLES(P_PROG), .SECTOR_ERASE_CYCLES(P_SE),
    .PROGRAM_SUSPEND_CYCLES(P_PS), .ERASE_SUSPEND_CYCLES(P_ES)) i_dut (.clk(clk), .reset_n(reset_n),
    .sck(sck), .cs_n(cs_n), .si(si), .addr32_mode(addr32_mode), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_addr_bytes(cmd_addr_bytes), .cmd_max_mhz(cmd_max_mhz),
    .write_in_progress_flag(write_in_progress_flag), .op_suspended(op_suspended), .op_done(op_done),
    .nv_pe_cycle(nv_pe_cycle));

  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic send(input logic [7:0] op, input logic [31:0] a, input int nb);
    i_host.frame(op, nb == 4 ? a : {a[23:0], 8'h0}, 8 + nb * 8);
  endtask : send
  // Bounded wait for a level, sampled mid-cycle; n returns cycles waited
  task automatic wait_for(input string what, ref logic s, input logic v, input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (s !== v && n < lim);
    chk(what, v, s);
  endtask : wait_for
  task automatic t_dec(input logic [7:0] op, input logic [3:0] code, input logic a32, input logic [7:0] mhz);
    int n;
    int nb;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      addr32_mode <= m[0];
      nb = (a32 || m == 1) ? 4 : 3;
      send(op, 32'h81a5c3e7, nb);
      wait_for("cmd_valid", cmd_valid, 1'b1, 40, n);
      chk("cmd_code", code, cmd_code);
      chk("cmd_opcode", op, cmd_opcode);
      chk("cmd_addr_bytes", nb, cmd_addr_bytes);
      chk("cmd_addr", nb == 4 ? 32'h81a5c3e7 : 32'h00a5c3e7, cmd_addr);
      chk("cmd_max_mhz", mhz, cmd_max_mhz);
      wait_for("idle", write_in_progress_flag, 1'b0, 2 * P_PROG, n);
    end
  endtask : t_dec
  task automatic t_bad();
    int n;
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    addr32_mode <= 1'b0;
    send(8'h03, 32'h0, 2);
    repeat (20) begin
      @(negedge clk);
      seen = seen | cmd_valid;
    end
    chk("short frame dropped", 1'b0, seen);
    send(8'h04, 32'h0, 0);
    wait_for("cmd_valid", cmd_valid, 1'b1, 40, n);
    chk("unknown code", sft_pkg::SFT_CMD_NONE, cmd_code);
    chk("unknown addr_bytes", 3'h0, cmd_addr_bytes);
  endtask : t_bad
  task automatic t_op(input logic [7:0] op, input logic [7:0] sus, input logic [7:0] res, input int dur, input int lat);
    int n;
    send(op, 32'h0, 3);
    wait_for("cmd_valid", cmd_valid, 1'b1, 40, n);
    wait_for("busy", write_in_progress_flag, 1'b1, 2, n);
    wait_for("op_done", op_done, 1'b1, dur + 4, n);
    chk("duration", 1'b1, n >= dur - 2 && n <= dur + 2);
    chk("idle at done", 1'b0, write_in_progress_flag);
    send(op, 32'h0, 3);
    wait_for("cmd_valid", cmd_valid, 1'b1, 40, n);
    send(sus, 32'h0, 0);
    wait_for("cmd_valid", cmd_valid, 1'b1, 40, n);
    wait_for("suspend latency", write_in_progress_flag, 1'b0, lat + 2, n);
    chk("op_suspended", 1'b1, op_suspended);
    send(res, 32'h0, 0);
    wait_for("cmd_valid", cmd_valid, 1'b1, 40, n);
    wait_for("resumed", write_in_progress_flag, 1'b1, 2, n);
    wait_for("op_done after resume", op_done, 1'b1, dur, n);
  endtask : t_op
  task automatic t_nv();
    int n;
    send(8'h01, 32'h0, 0);
    wait_for("cmd_valid", cmd_valid, 1'b1, 40, n);
    chk("nv_pe_cycle", 1'b1, nv_pe_cycle);
    send(8'h42, 32'h0, 0);
    wait_for("cmd_valid", cmd_valid, 1'b1, 40, n);
    chk("otp nv_pe_cycle", 1'b0, nv_pe_cycle);
  endtask : t_nv

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_dec(8'h02, sft_pkg::SFT_CMD_PAGE_PROGRAM, 1'b0, 8'h85);
    t_dec(8'h12, sft_pkg::SFT_CMD_PAGE_PROGRAM, 1'b1, 8'h85);
    t_dec(8'h03, sft_pkg::SFT_CMD_NORMAL_READ, 1'b0, 8'h32);
    t_dec(8'h13, sft_pkg::SFT_CMD_NORMAL_READ, 1'b1, 8'h32);
    t_dec(8'h0b, sft_pkg::SFT_CMD_FAST_READ, 1'b0, 8'h85);
    t_dec(8'h0c, sft_pkg::SFT_CMD_FAST_READ, 1'b1, 8'h85);
    t_dec(8'h0d, sft_pkg::SFT_CMD_DDR_FAST_READ, 1'b0, 8'h50);
    t_dec(8'h0e, sft_pkg::SFT_CMD_DDR_FAST_READ, 1'b1, 8'h50);
    t_dec(8'h32, sft_pkg::SFT_CMD_QUAD_PROGRAM, 1'b0, 8'h50);
    t_dec(8'h38, sft_pkg::SFT_CMD_QUAD_PROGRAM, 1'b0, 8'h50);
    t_dec(8'h34, sft_pkg::SFT_CMD_QUAD_PROGRAM, 1'b1, 8'h50);
    t_dec(8'h3b, sft_pkg::SFT_CMD_DUAL_OUT_READ, 1'b0, 8'h68);
    t_dec(8'hdc, sft_pkg::SFT_CMD_SECTOR_ERASE, 1'b1, 8'h85);
    t_bad();
    t_op(8'h02, 8'h85, 8'h8a, P_PROG, P_PS);
    t_op(8'hd8, 8'h75, 8'h7a, P_SE, P_ES);
    t_nv();
    end_sim();
  end
  // Watchdog: the sequence needs well under half of this span
  initial begin
    #600000;
    fail_count++;
    end_sim();
  end
endmodule : tb
`default_nettype wire
